/* File: core/ldic_consts.svh */
`ifndef LDIC_CONSTS_SVH
`define LDIC_CONSTS_SVH

// Data bus width seen by the auxiliary control register
`define LDIC_DATA_W            8
// Field positions inside auxiliary_line_interrupt_control
`define LDIC_LOCKOUT_BIT       5
`define LDIC_LINE_SEL_BIT      6
`define LDIC_IRQ_BIT           7
// Mask of the bits that are stored; the rest read as zero
`define LDIC_STORED_MASK       8'he0
// Reset value of the register: coax, no interrupt, lock-out off
`define LDIC_REG_RESET         8'h00
// Line-select encoding
`define LDIC_SEL_COAX          1'h0
`define LDIC_SEL_TWINAX        1'h1
// Number of asynchronous inputs that are synchronised
`define LDIC_SYNC_W            16
// Reset levels of the combinational-path outputs
`define LDIC_XOR_N_RESET       1'h1
`define LDIC_BRST_N_RESET      1'h0

`endif

/* File: core/ldic_pkg.sv */
`default_nettype none

package ldic_pkg;

   // Strobe tracking states, one-hot
   typedef enum logic [2:0] {
      LDIC_ST_IDLE  = 3'h1,
      LDIC_ST_LOW   = 3'h2,
      LDIC_ST_LATCH = 3'h4
   } ldic_strobe_e;

   typedef logic [7:0] ldic_reg_t;

endpackage : ldic_pkg

`default_nettype wire

/* File: core/ldic_sync.sv */
`default_nettype none

// Two-stage synchroniser, one chain per bit
module ldic_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   if (WIDTH < 1) begin : g_width_check
      $error("ldic_sync: WIDTH must be at least 1");
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic stage1;
         logic stage2;
         logic next_stage1;
         logic next_stage2;

         always_comb begin
            next_stage1 = async_in[i];
            next_stage2 = stage1;
         end

         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               stage1 <= 1'h0;
               stage2 <= 1'h0;
            end else begin
               stage1 <= next_stage1;
               stage2 <= next_stage2;
            end
         end

         assign sync_out[i] = stage2;
      end
   endgenerate

endmodule // ldic_sync

`default_nettype wire

/* File: core/ldic_line_drive_irq_control.sv */
`include "ldic_consts.svh"

`default_nettype none

// Operation
// [R01] Coax drive: select low, transmitting, not reset
// [R02] Twinax drive: select high, transmitting, not reset
// [R03] Intensity low when serial and delayed differ
// [R04] Data bit 6 low selects coax
// [R05] Bits 7 and 5 load irq, lock-out
// [R06] Irq set by bit 7 one, cleared zero
// [R07] Registered outputs driven only while enable low
// [R08] Line drives, intensity, board reset always driven
// [R09] Loopback lets receiver run while transmitting
// [R10] Update on strobe rise; board reset inverted
module ldic_line_drive_irq_control #(
   parameter int DATA_W = `LDIC_DATA_W
) (
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic [DATA_W-1:0] proc_data,
   input  wire logic              aux_register_strobe_n,
   input  wire logic              output_enable_n,
   input  wire logic              tx_active,
   input  wire logic              proc_reset_n,
   input  wire logic              serial_out,
   input  wire logic              serial_out_delayed,
   input  wire logic              host_reset_in,
   input  wire logic              loopback_test,
   input  wire logic              rx_request,
   output var  logic              coax_line_drive,
   output var  logic              twinax_line_drive,
   output var  logic              encoded_xor_out_n,
   output var  logic              board_reset_out_n,
   output var  logic              host_irq,
   output var  logic              host_irq_oe,
   output var  logic              host_lockout_enable,
   output var  logic              host_lockout_enable_oe,
   output var  logic              line_select,
   output var  logic              line_select_oe,
   output var  logic              rx_enable
);

   if (DATA_W < `LDIC_DATA_W) begin : g_width_check
      $error("ldic: DATA_W must be at least 8");
   end

   // Synchronised copies of every pin input except rx_request
   logic [`LDIC_SYNC_W-1:0] async_bus;
   logic [`LDIC_SYNC_W-1:0] sync_bus;

   always_comb begin
      async_bus      = '0;
      async_bus[7:0] = proc_data[7:0];
      // Strobe, enable and host reset cross inverted: reset reads strobe and enable idle, host reset asserted
      async_bus[8]   = ~aux_register_strobe_n;
      async_bus[9]   = ~output_enable_n;
      async_bus[10]  = tx_active;
      async_bus[11]  = proc_reset_n;
      async_bus[12]  = serial_out;
      async_bus[13]  = serial_out_delayed;
      async_bus[14]  = ~host_reset_in;
      async_bus[15]  = loopback_test;
   end

   ldic_sync #(
      .WIDTH (`LDIC_SYNC_W)
   ) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in (async_bus),
      .sync_out (sync_bus)
   );

   logic [7:0] s_data;
   logic       s_strobe_n;
   logic       s_oe_n;
   logic       s_tx_active;
   logic       s_proc_rst_n;
   logic       s_serial;
   logic       s_serial_dly;
   logic       s_host_rst;
   logic       s_loopback;

   always_comb begin
      s_data       = sync_bus[7:0];
      s_strobe_n   = ~sync_bus[8];
      s_oe_n       = ~sync_bus[9];
      s_tx_active  = sync_bus[10];
      s_proc_rst_n = sync_bus[11];
      s_serial     = sync_bus[12];
      s_serial_dly = sync_bus[13];
      s_host_rst   = ~sync_bus[14];
      s_loopback   = sync_bus[15];
   end

   // Receive request comes from logic on this clock
   logic s_rx_request;

   always_comb begin
      s_rx_request = rx_request;
   end

   // Strobe tracking
   ldic_pkg::ldic_strobe_e strobe_state;
   ldic_pkg::ldic_strobe_e next_strobe_state;
   logic                   strobe_rise;

   always_comb begin
      next_strobe_state = strobe_state;
      strobe_rise       = 1'h0;
      case (strobe_state)
         ldic_pkg::LDIC_ST_IDLE: begin
            if (!s_strobe_n) begin
               next_strobe_state = ldic_pkg::LDIC_ST_LOW;
            end
         end
         ldic_pkg::LDIC_ST_LOW: begin
            if (s_strobe_n) begin
               next_strobe_state = ldic_pkg::LDIC_ST_LATCH;
               strobe_rise       = 1'h1; // [R10]
            end
         end
         ldic_pkg::LDIC_ST_LATCH: begin
            if (!s_strobe_n) begin
               next_strobe_state = ldic_pkg::LDIC_ST_LOW;
            end else begin
               next_strobe_state = ldic_pkg::LDIC_ST_IDLE;
            end
         end
         default: begin
            next_strobe_state = ldic_pkg::LDIC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         strobe_state <= ldic_pkg::LDIC_ST_IDLE;
      end else begin
         strobe_state <= next_strobe_state;
      end
   end

   // Data is held one cycle so it matches the strobe rise sample
   logic [7:0] data_hold;
   logic [7:0] next_data_hold;

   always_comb begin
      next_data_hold = s_data;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         data_hold <= 8'h00;
      end else begin
         data_hold <= next_data_hold;
      end
   end

   // Auxiliary control register, write-only from the processor
   ldic_pkg::ldic_reg_t auxiliary_line_interrupt_control;
   ldic_pkg::ldic_reg_t next_aux;

   always_comb begin
      next_aux = auxiliary_line_interrupt_control;
      if (strobe_rise) begin
         // Bit 6 picks the line, bits 7 and 5 load irq and lock-out
         next_aux = data_hold & `LDIC_STORED_MASK; // [R04] [R05] [R06] [R10]
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         auxiliary_line_interrupt_control <= `LDIC_REG_RESET;
      end else begin
         auxiliary_line_interrupt_control <= next_aux;
      end
   end

   logic sel_twinax;
   logic irq_bit;
   logic lockout_bit;

   always_comb begin
      sel_twinax  = auxiliary_line_interrupt_control[`LDIC_LINE_SEL_BIT];
      irq_bit     = auxiliary_line_interrupt_control[`LDIC_IRQ_BIT];
      lockout_bit = auxiliary_line_interrupt_control[`LDIC_LOCKOUT_BIT];
   end

   // Output stage, every output registered
   logic next_coax;
   logic next_twinax;
   logic next_xor_n;
   logic next_brst_n;
   logic next_irq;
   logic next_irq_oe;
   logic next_lockout;
   logic next_lockout_oe;
   logic next_sel;
   logic next_sel_oe;
   logic next_rx_en;
   logic line_active;

   always_comb begin
      line_active  = s_tx_active & s_proc_rst_n;
      next_coax    = (sel_twinax == `LDIC_SEL_COAX) & line_active;   // [R01]
      next_twinax  = (sel_twinax == `LDIC_SEL_TWINAX) & line_active; // [R02]
      next_xor_n   = ~(s_serial ^ s_serial_dly);                     // [R03]
      next_brst_n  = ~s_host_rst;                                    // [R10]
      next_irq     = irq_bit;                                        // [R06]
      next_lockout = lockout_bit;                                    // [R05]
      next_sel     = sel_twinax;                                     // [R04]
      next_irq_oe     = ~s_oe_n;                                     // [R07]
      next_lockout_oe = ~s_oe_n;                                     // [R07]
      next_sel_oe     = ~s_oe_n;                                     // [R07]
      // Receiver is muted while transmitting unless looping back
      next_rx_en   = s_rx_request & (~s_tx_active | s_loopback);     // [R09]
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         coax_line_drive        <= 1'h0;
         twinax_line_drive      <= 1'h0;
         encoded_xor_out_n      <= `LDIC_XOR_N_RESET;
         board_reset_out_n      <= `LDIC_BRST_N_RESET;
         host_irq               <= 1'h0;
         host_irq_oe            <= 1'h0;
         host_lockout_enable    <= 1'h0;
         host_lockout_enable_oe <= 1'h0;
         line_select            <= 1'h0;
         line_select_oe         <= 1'h0;
         rx_enable              <= 1'h0;
      end else begin
         // Four line outputs have no enable and stay driven
         coax_line_drive        <= next_coax;   // [R08]
         twinax_line_drive      <= next_twinax; // [R08]
         encoded_xor_out_n      <= next_xor_n;  // [R08]
         board_reset_out_n      <= next_brst_n; // [R08]
         host_irq               <= next_irq;
         host_irq_oe            <= next_irq_oe;
         host_lockout_enable    <= next_lockout;
         host_lockout_enable_oe <= next_lockout_oe;
         line_select            <= next_sel;
         line_select_oe         <= next_sel_oe;
         rx_enable              <= next_rx_en;
      end
   end

endmodule // ldic_line_drive_irq_control

`default_nettype wire

/* File: core/ldic_dummy_unused.sv */
`default_nettype none
`default_nettype wire

/* File: verification/ldic_props.sv */
`default_nettype none

module ldic_props (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic aux_register_strobe_n,
   input wire logic output_enable_n,
   input wire logic tx_active,
   input wire logic proc_reset_n,
   input wire logic serial_out,
   input wire logic serial_out_delayed,
   input wire logic host_reset_in,
   input wire logic loopback_test,
   input wire logic rx_request,
   input wire logic coax_line_drive,
   input wire logic twinax_line_drive,
   input wire logic encoded_xor_out_n,
   input wire logic board_reset_out_n,
   input wire logic host_irq,
   input wire logic host_irq_oe,
   input wire logic line_select,
   input wire logic line_select_oe,
   input wire logic rx_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   coax_sel_a: assert property (coax_line_drive |-> !line_select)
      else $error("coax drive with twinax selected");
   twx_sel_a: assert property (twinax_line_drive |-> line_select)
      else $error("twinax drive with coax selected");
   one_drive_a: assert property ((tx_active && proc_reset_n)[*5]
      |-> coax_line_drive != twinax_line_drive)
      else $error("line drives not exclusive while sending");
   xor_out_a: assert property (($stable(serial_out)
      && $stable(serial_out_delayed))[*5]
      |-> encoded_xor_out_n == (serial_out ~^ serial_out_delayed))
      else $error("intensity output wrong");
   brst_out_a: assert property (($stable(host_reset_in))[*5]
      |-> board_reset_out_n == !host_reset_in)
      else $error("board reset not inverse of host reset");
   oe_follow_a: assert property (($stable(output_enable_n))[*5]
      |-> host_irq_oe == !output_enable_n
      && line_select_oe == !output_enable_n)
      else $error("output enable wrong");
   rx_req_a: assert property (rx_enable |-> $past(rx_request))
      else $error("receiver enabled without request");
   rx_mute_a: assert property ((tx_active && !loopback_test)[*5]
      |-> !rx_enable)
      else $error("receiver enabled while sending");
   reg_hold_a: assert property (aux_register_strobe_n[*8]
      |-> $stable(host_irq) && $stable(line_select))
      else $error("stored bit changed without a write");
   cover property (host_irq);
   cover property (twinax_line_drive);
   cover property (rx_enable && tx_active);
endmodule // ldic_props

bind ldic_line_drive_irq_control ldic_props u_props (
   .ref_clk               (ref_clk),
   .resetn                (resetn),
   .aux_register_strobe_n (aux_register_strobe_n),
   .output_enable_n       (output_enable_n),
   .tx_active             (tx_active),
   .proc_reset_n          (proc_reset_n),
   .serial_out            (serial_out),
   .serial_out_delayed    (serial_out_delayed),
   .host_reset_in         (host_reset_in),
   .loopback_test         (loopback_test),
   .rx_request            (rx_request),
   .coax_line_drive       (coax_line_drive),
   .twinax_line_drive     (twinax_line_drive),
   .encoded_xor_out_n     (encoded_xor_out_n),
   .board_reset_out_n     (board_reset_out_n),
   .host_irq              (host_irq),
   .host_irq_oe           (host_irq_oe),
   .line_select           (line_select),
   .line_select_oe        (line_select_oe),
   .rx_enable             (rx_enable)
);

`default_nettype wire

/* File: verification/ldic_proc_model.sv */
`default_nettype none

module ldic_proc_model (
   input  wire logic       ref_clk,
   input  wire logic       wr_req,
   input  wire logic [7:0] wr_data,
   output var  logic [7:0] proc_data,
   output var  logic       aux_register_strobe_n,
   output var  logic       wr_done
);
   timeunit 1ns;
   timeprecision 1ns;
   // One register write per request
   initial begin
      proc_data = 8'h00;
      aux_register_strobe_n = 1'h1;
      wr_done = 1'h0;
      forever begin
         @(posedge ref_clk);
         if (wr_req) begin
            proc_data <= wr_data;
            aux_register_strobe_n <= 1'h0;
            repeat (3) @(posedge ref_clk);
            aux_register_strobe_n <= 1'h1;
            repeat (3) @(posedge ref_clk);
            proc_data <= ~wr_data;
            wr_done <= 1'h1;
            @(posedge ref_clk);
            wr_done <= 1'h0;
            repeat (2) @(posedge ref_clk);
         end
      end
   end
endmodule // ldic_proc_model

`default_nettype wire

/* File: verification/tb_top.sv */
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk = 1'h0;
   logic       resetn = 1'h0;
   logic [7:0] proc_data;
   logic [7:0] wr_data = 8'h00;
   logic       wr_req = 1'h0;
   logic       aux_register_strobe_n, wr_done;
   logic       output_enable_n = 1'h0, tx_active = 1'h0;
   logic       proc_reset_n = 1'h1, serial_out = 1'h0;
   logic       serial_out_delayed = 1'h0, host_reset_in = 1'h0;
   logic       loopback_test = 1'h0, rx_request = 1'h0;
   logic       coax_line_drive, twinax_line_drive, encoded_xor_out_n;
   logic       board_reset_out_n, host_irq, host_irq_oe, line_select;
   logic       host_lockout_enable, host_lockout_enable_oe;
   logic       line_select_oe, rx_enable;
   int         miscompares = 0;
   int         n_compared = 0;

   always #50 ref_clk = ~ref_clk;

   ldic_line_drive_irq_control DUT (
      .ref_clk                (ref_clk),
      .resetn                 (resetn),
      .proc_data              (proc_data),
      .aux_register_strobe_n  (aux_register_strobe_n),
      .output_enable_n        (output_enable_n),
      .tx_active              (tx_active),
      .proc_reset_n           (proc_reset_n),
      .serial_out             (serial_out),
      .serial_out_delayed     (serial_out_delayed),
      .host_reset_in          (host_reset_in),
      .loopback_test          (loopback_test),
      .rx_request             (rx_request),
      .coax_line_drive        (coax_line_drive),
      .twinax_line_drive      (twinax_line_drive),
      .encoded_xor_out_n      (encoded_xor_out_n),
      .board_reset_out_n      (board_reset_out_n),
      .host_irq               (host_irq),
      .host_irq_oe            (host_irq_oe),
      .host_lockout_enable    (host_lockout_enable),
      .host_lockout_enable_oe (host_lockout_enable_oe),
      .line_select            (line_select),
      .line_select_oe         (line_select_oe),
      .rx_enable              (rx_enable)
   );

   ldic_proc_model u_proc (
      .ref_clk               (ref_clk),
      .wr_req                (wr_req),
      .wr_data               (wr_data),
      .proc_data             (proc_data),
      .aux_register_strobe_n (aux_register_strobe_n),
      .wr_done               (wr_done)
   );

   task automatic chk(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] d);
      wr_data <= d;
      wr_req <= 1'h1;
      do @(posedge ref_clk); while (wr_done !== 1'h1);
      wr_req <= 1'h0;
      wt(3);
   endtask

   task automatic t_reg;
      logic [7:0] d;
      for (int k = 0; k < 8; k++) begin
         d = {k[0], k[1], k[2], 5'h15};
         wr(d);
         chk(host_irq, d[7]);
         chk(line_select, d[6]);
         chk(host_lockout_enable, d[5]);
      end
   endtask

   // Mid-run reset clears the register and no false write follows
   task automatic t_rst;
      wr(8'h80);
      chk(host_irq, 1'h1);
      resetn <= 1'h0;
      wt(2);
      chk(host_irq, 1'h0);
      chk(board_reset_out_n, 1'h0);
      resetn <= 1'h1;
      wt(8);
      chk(line_select, 1'h0);
      chk(host_lockout_enable, 1'h0);
      chk(host_irq, 1'h0);
      chk(board_reset_out_n, !host_reset_in);
      wr(8'h40);
      chk(line_select, 1'h1);
      chk(host_irq, 1'h0);
   endtask

   task automatic t_line;
      for (int k = 0; k < 8; k++) begin
         wr({1'h0, k[0], 6'h3f});
         tx_active <= k[1];
         proc_reset_n <= k[2];
         wt(6);
         chk(coax_line_drive, !k[0] && k[1] && k[2]);
         chk(twinax_line_drive, k[0] && k[1] && k[2]);
      end
   endtask

   task automatic t_comb;
      for (int k = 0; k < 8; k++) begin
         serial_out <= k[0];
         serial_out_delayed <= k[1];
         host_reset_in <= k[2];
         output_enable_n <= k[1];
         wt(5);
         chk(encoded_xor_out_n, k[0] == k[1]);
         chk(board_reset_out_n, !k[2]);
         chk(host_irq_oe, !k[1]);
         chk(line_select_oe, !k[1]);
         chk(host_lockout_enable_oe, !k[1]);
      end
   endtask

   task automatic t_loop;
      for (int k = 0; k < 8; k++) begin
         rx_request <= k[0];
         tx_active <= k[1];
         loopback_test <= k[2];
         wt(5);
         chk(rx_enable, k[0] && (!k[1] || k[2]));
      end
   endtask

   task automatic summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      wt(4);
      chk(host_irq, 1'h0);
      chk(encoded_xor_out_n, 1'h1);
      chk(board_reset_out_n, 1'h0);
      resetn <= 1'h1;
      wt(2);
      t_reg;
      t_line;
      t_comb;
      t_rst;
      t_loop;
      summarize;
   end

   initial begin
      wt(3000);
      miscompares++;
      summarize;
   end
endmodule // tb_top

`default_nettype wire
